// ===== logic/clock_select_defines.vh
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// Register address of clock_source_select
`define CLKSRC_ADDR        8'ha9
`define CLKSRC_RESET       8'h00
// source_select_field position
`define SRCSEL_LSB         0
`define SRCSEL_MSB         1
`define SRCSEL_RESET       2'h0
// source_select_field codes
`define SRC_HF             2'h0
`define SRC_EXT            2'h1
`define SRC_LF             2'h2
`define SRC_RSVD           2'h3
// Divider field reset: code 3 means divide by 8
`define HF_DIV_RESET       2'h3
`define LF_DIV_RESET       2'h3
// Source index into the mux
`define IDX_HF             0
`define IDX_EXT            1
`define IDX_LF             2

`endif

// ===== logic/pow2_divider.v
`timescale 1ns/100ps
// ==========================================================
// Divides a sampled oscillator level by 1, 2, 4 or 8
module pow2_divider
(
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       src_i,
  input  wire [1:0] div_sel_i,
  output wire       div_o
);

  reg       src_d_reg;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg       out_reg;
  reg       out_next;

  always @*
  begin
    cnt_next = cnt_reg;
    if (src_i && !src_d_reg)
      cnt_next = cnt_reg + 3'h1;
    case (div_sel_i)
      2'h0:    out_next = src_i;
      2'h1:    out_next = cnt_next[0];
      2'h2:    out_next = cnt_next[1];
      default: out_next = cnt_next[2];
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      src_d_reg <= 1'b0;
      cnt_reg   <= 3'h0;
      out_reg   <= 1'b0;
    end
    else
    begin
      src_d_reg <= src_i;
      cnt_reg   <= cnt_next;
      out_reg   <= out_next;
    end
  end

  assign div_o = out_reg;

endmodule

// ===== logic/system_clock_source_select.v
`timescale 1ns/100ps
// Operation
// - Select field: 00 HF, 01 ext, 10 LF
// - External drives core for code 01, and stays on if 11 follows
// - External still clocks timers, counter array
// - Switch live; software picks running source
// - Internal oscillators usable with no wait
// - External RC/C modes need no wait
// - Upper six bits read zero, ignore writes
// - Reset selects internal high-frequency source
// - HF divided 1/2/4/8, default 8
`include "clock_select_defines.vh"

module system_clock_source_select
#(
  parameter NUM_SRC = 3
)
(
  input  wire       core_clk_i,
  input  wire       srst_i,
  // Register port
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire [7:0] sfr_wdata_i,
  output wire [7:0] sfr_rdata_o,
  // Divider fields, loaded on their write strobes
  input  wire [1:0] hf_divider_field_i,
  input  wire       hf_divider_wr_i,
  input  wire [1:0] lf_divider_field_i,
  input  wire       lf_divider_wr_i,
  // Sampled oscillator levels
  input  wire       hf_osc_i,
  input  wire       ext_osc_i,
  input  wire       lf_osc_i,
  // Clocks out
  output wire       core_clock_o,
  output wire       ext_periph_clock_o,
  output wire [2:0] active_source_o
);

  // ========================================================
  // Registers
  reg [1:0] source_select_field_reg;
  reg [1:0] hf_div_reg;
  reg [1:0] lf_div_reg;
  reg [7:0] rdata_reg;

  // ========================================================
  // Write decode
  // A select field write needs the strobe and the address together
  wire csel_hit;
  wire csel_wr;

  assign csel_hit = (sfr_addr_i == `CLKSRC_ADDR);
  assign csel_wr  = sfr_wr_i && csel_hit;

  // ========================================================
  // Source select field
  // Only bits 1:0 are kept; the other six write bits are dropped
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      source_select_field_reg <= `SRCSEL_RESET;
    else if (csel_wr)
      source_select_field_reg <=
        sfr_wdata_i[`SRCSEL_MSB:`SRCSEL_LSB];
  end

  // ========================================================
  // Divider fields
  // Both dividers come out of reset dividing by 8
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      hf_div_reg <= `HF_DIV_RESET;
    else if (hf_divider_wr_i)
      hf_div_reg <= hf_divider_field_i;
  end

  always @(posedge core_clk_i)
  begin
    if (srst_i)
      lf_div_reg <= `LF_DIV_RESET;
    else if (lf_divider_wr_i)
      lf_div_reg <= lf_divider_field_i;
  end

  // ========================================================
  // Read path
  // Upper six bits always read zero; other addresses read zero
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      rdata_reg <= `CLKSRC_RESET;
    else if (csel_hit)
      rdata_reg <= {6'h00, source_select_field_reg};
    else
      rdata_reg <= 8'h00;
  end

  assign sfr_rdata_o = rdata_reg;

  // ========================================================
  // Post-scaled internal sources
  // Both dividers count rising edges of their source
  wire hf_scaled;
  wire lf_scaled;

  pow2_divider u_hf_div
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .src_i      (hf_osc_i),
    .div_sel_i  (hf_div_reg),
    .div_o      (hf_scaled)
  );

  pow2_divider u_lf_div
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .src_i      (lf_osc_i),
    .div_sel_i  (lf_div_reg),
    .div_o      (lf_scaled)
  );

  // ========================================================
  // Source decode
  wire [NUM_SRC-1:0] src_lvl;
  reg  [NUM_SRC-1:0] want;
  wire               rsvd;

  assign src_lvl[`IDX_HF]  = hf_scaled;
  assign src_lvl[`IDX_EXT] = ext_osc_i;
  assign src_lvl[`IDX_LF]  = lf_scaled;

  assign rsvd = (source_select_field_reg == `SRC_RSVD);

  // The reserved code asks for no source at all
  always @*
  begin
    want = {NUM_SRC{1'b0}};
    case (source_select_field_reg)
      `SRC_HF:  want[`IDX_HF]  = 1'b1;
      `SRC_EXT: want[`IDX_EXT] = 1'b1;
      `SRC_LF:  want[`IDX_LF]  = 1'b1;
      default:  want = {NUM_SRC{1'b0}};
    endcase
  end

  // ========================================================
  // Glitch-free mux
  // An enable only changes while its own source is low, so the
  // core clock is never cut inside a high phase. The new enable
  // rises only once every other enable has dropped, which leaves
  // a low gap between the two sources rather than an overlap.
  // The reserved code freezes the enables where they stand; if
  // written in mid-changeover the core clock stays low.
  // No start-up wait is added for any source.
  localparam [NUM_SRC-1:0] EN_RESET =
    {{(NUM_SRC-1){1'b0}}, 1'b1} << `IDX_HF;

  reg  [NUM_SRC-1:0] en_reg;
  reg                core_clock_reg;
  reg                ext_clock_reg;

  genvar k;
  generate
    for (k = 0; k < NUM_SRC; k = k + 1)
    begin : g_sel
      wire others;
      wire src_low;
      wire en_next;

      // Any enable other than this one
      assign others  = |(en_reg & ~({{(NUM_SRC-1){1'b0}}, 1'b1} << k));
      assign src_low = !src_lvl[k];
      // A new source waits until every other enable is clear
      assign en_next = want[k] && !others;
      always @(posedge core_clk_i)
      begin
        if (srst_i)
          en_reg[k] <= EN_RESET[k];
        else if (src_low && !rsvd)
          en_reg[k] <= en_next;
      end
    end
  endgenerate

  // ========================================================
  // Core clock
  // Only an enabled source passes; none while changing over
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      core_clock_reg <= 1'b0;
    else
      core_clock_reg <= |(en_reg & src_lvl);
  end

  // ========================================================
  // Peripheral clock
  // Runs from the external source whatever the field holds
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      ext_clock_reg <= 1'b0;
    else
      ext_clock_reg <= ext_osc_i;
  end

  // ========================================================
  // Outputs
  assign core_clock_o       = core_clock_reg;
  assign ext_periph_clock_o = ext_clock_reg;
  assign active_source_o    = en_reg;

endmodule

// ===== dv/osc_model.sv
`timescale 1ns/100ps
module osc_model
(
  input  wire core_clk_i,
  output reg  hf_o = 1'h0,
  output reg  ext_o = 1'h0,
  output reg  lf_o = 1'h0
);
  integer n = 0;
  always @(posedge core_clk_i)
  begin
    n <= n + 1;
    hf_o <= #1 ~hf_o;
    ext_o <= #1 n % 6 < 3;
    lf_o <= #1 n % 10 < 5;
  end
endmodule

// ===== dv/clk_sel_sva.sv
`timescale 1ns/100ps
module clk_sel_sva
(
  input wire       core_clk_i,
  input wire       srst_i,
  input wire       ext_osc_i,
  input wire [7:0] sfr_rdata_o,
  input wire       core_clock_o,
  input wire       ext_periph_clock_o,
  input wire [2:0] active_source_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_one_src: assert property ($onehot0(active_source_o))
    else $error("onehot");
  a_gap_first: assert property (!$past(srst_i) &&
    $changed(active_source_o) && active_source_o != 3'h0 |->
    $past(active_source_o) == 3'h0) else $error("gap");
  a_ext_core: assert property (active_source_o == 3'h2 |=>
    core_clock_o == $past(ext_osc_i)) else $error("ext");
  a_ext_periph: assert property (!$past(srst_i) |->
    ext_periph_clock_o == $past(ext_osc_i)) else $error("periph");
  a_reset_hf: assert property ($past(srst_i) |->
    active_source_o == 3'h1) else $error("reset source");
  a_gap_low: assert property (active_source_o == 3'h0 |=>
    !core_clock_o) else $error("gap clock");
  a_read_upper: assert property (sfr_rdata_o[7:2] == 6'h00)
    else $error("read upper");
endmodule
bind system_clock_source_select clk_sel_sva u_sva (.core_clk_i, .srst_i,
  .ext_osc_i, .sfr_rdata_o, .core_clock_o, .ext_periph_clock_o,
  .active_source_o);

// ===== dv/system_clock_source_select_tb.sv
`timescale 1ns/100ps
module system_clock_source_select_tb;
  logic       core_clk_i = 1'h0, srst_i = 1'h1, sfr_wr_i = 1'h0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  logic [1:0] dv = 2'h0, c;
  wire  [7:0] rd;
  wire  [2:0] act;
  wire        hf, ext, lf, ck, ep;
  integer     err_total = 0, cmp_count = 0, i, w, u, cur = 0;
  initial forever #5 core_clk_i = ~core_clk_i;
  osc_model osc (.core_clk_i, .hf_o(hf), .ext_o(ext), .lf_o(lf));
  system_clock_source_select DUT (.core_clk_i, .srst_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o(rd), .hf_divider_field_i(dv),
    .hf_divider_wr_i(sfr_wr_i), .lf_divider_field_i(dv),
    .lf_divider_wr_i(sfr_wr_i), .hf_osc_i(hf), .ext_osc_i(ext),
    .lf_osc_i(lf), .core_clock_o(ck), .ext_periph_clock_o(ep),
    .active_source_o(act));
  task chk(input logic [31:0] s, e, input string n);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task tick;
    @(posedge core_clk_i) #1;
  endtask
  task wr(input logic [7:0] ad, d);
    sfr_addr_i = ad;
    sfr_wdata_i = d;
    sfr_wr_i = 1'h1;
    tick;
    sfr_wr_i = 1'h0;
    tick;
  endtask
  task hi(input integer e);
    do tick; while (ck !== 1'h0);
    do tick; while (ck !== 1'h1);
    for (w = 0; ck === 1'h1; w++) tick;
    chk(w, e, "width");
  endtask
  task final_report;
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) tick;
    err_total++;
    final_report;
  end
  initial
  begin
    void'($urandom(86));
    repeat (5) tick;
    chk(act, 3'h1, "reset");
    srst_i = 1'h0;
    hi(8);
    for (i = 0; i < 16; i++)
    begin
      c = 2'(i < 4 ? i : $urandom);
      dv = 2'($urandom);
      u = i % 5 == 4;
      wr(u ? 8'h5a : 8'ha9, {6'($urandom), c});
      chk(rd, u ? 8'h00 : {6'h00, c}, "read");
      @(negedge core_clk_i) w = ext;
      tick;
      chk(ep, w, "periph");
      if (!u && c != 2'h3)
        cur = c;
      repeat (200) if (act !== 3'h1 << cur) tick;
      chk(act, 3'h1 << cur, "source");
      hi(cur == 1 ? 3 : cur == 0 ? 1 << dv : 5 << dv);
    end
    final_report;
  end
endmodule
